/* File: inc/seqb_defs.svh */
`ifndef SEQB_DEFS_SVH
`define SEQB_DEFS_SVH

// register byte offsets
`define SEQB_CONTROL_OFS 12'h00c
`define SEQB_RESULT_OFS  12'h014
`define SEQB_AUX_OFS     12'h040

// control register fields
`define SEQB_CHAN_LSB    0
`define SEQB_CHAN_W      12
`define SEQB_POL_BIT     18
`define SEQB_START_BIT   26
`define SEQB_BURST_BIT   27
`define SEQB_STEP_BIT    28
`define SEQB_MODE_BIT    30
`define SEQB_ENABLE_BIT  31
`define SEQB_CONTROL_RST 32'h0000_0000

// global result register fields
`define SEQB_RES_LSB     4
`define SEQB_CHN_LSB     26
`define SEQB_OVR_BIT     30
`define SEQB_VALID_BIT   31

// auxiliary status and control fields
`define SEQB_AUX_FLAG_BIT  0
`define SEQB_AUX_OVRIE_BIT 1
`define SEQB_AUX_BUSY_BIT  2

`endif

/* File: inc/seqb_pkg.sv */
package seqb_pkg;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_CONV = 1'b1
  } seq_state_t;

  typedef enum logic [1:0] {
    SEL_NONE   = 2'b00,
    SEL_CTRL   = 2'b01,
    SEL_RESULT = 2'b10,
    SEL_AUX    = 2'b11
  } reg_sel_t;

endpackage : seqb_pkg

/* File: core/trig_sync.sv */
`timescale 1ns/100ps
module trig_sync
(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // asynchronous level in, synchronised level out
  input  wire logic async_in,
  output logic      sync_out
);

  logic meta_r;
  logic meta_nxt;
  logic sync_r;
  logic sync_nxt;

  always_comb
  begin
    meta_nxt = async_in;
    sync_nxt = meta_r;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end
    else
    begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_out = sync_r;

endmodule : trig_sync

/* File: core/seqb_launch.sv */
// Register access over APB is this design's own decision.
`timescale 1ns/100ps
`include "seqb_defs.svh"

module seqb_launch
  import seqb_pkg::*;
(
  // apb slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // hardware trigger pin
  input  wire logic        trig_pin,
  // converter core
  output logic             conv_start,
  output logic      [3:0]  conv_chan,
  input  wire logic        conv_done,
  input  wire logic [11:0] conv_result,
  // flags to interrupt and dma logic
  input  wire logic        dma_clear,
  output logic             seq_flag,
  output logic             overrun_flag
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic reg_sel_t decode(input logic [11:0] a);
    if (a == `SEQB_CONTROL_OFS)
      return SEL_CTRL;
    else if (a == `SEQB_RESULT_OFS)
      return SEL_RESULT;
    else if (a == `SEQB_AUX_OFS)
      return SEL_AUX;
    else
      return SEL_NONE;
  endfunction : decode

  // {found, index} of lowest enabled channel at or above from
  function automatic logic [4:0] find_chan(input logic [11:0] mask,
                                           input logic [4:0]  from);
    logic [4:0] res;
    res = 5'h00;
    for (int i = 11; i >= 0; i--)
    begin
      if (mask[i] && (5'(i) >= from))
        res = {1'b1, 4'(i)};
    end
    return res;
  endfunction : find_chan

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  reg_sel_t sel;
  logic     wr_acc;
  logic     rd_acc;
  logic     setup;
  logic     start_pulse;
  logic     rd_clear;

  assign sel         = decode(paddr);
  assign setup       = psel && !penable;
  assign wr_acc      = psel && penable && pwrite;
  assign rd_acc      = psel && penable && !pwrite;
  assign pready      = 1'b1;
  assign pslverr     = psel && penable && (sel == SEL_NONE);
  assign start_pulse = wr_acc && (sel == SEL_CTRL) && pwdata[`SEQB_START_BIT];
  // clear with the snapshot so no result slips in between
  assign rd_clear    = setup && !pwrite && (sel == SEL_RESULT);

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers

  logic [11:0] chan_r, chan_nxt;
  logic        pol_r, pol_nxt;
  logic        burst_r, burst_nxt;
  logic        step_r, step_nxt;
  logic        mode_r, mode_nxt;
  logic        ena_r, ena_nxt;
  logic        ovr_ie_r, ovr_ie_nxt;

  always_comb
  begin
    chan_nxt   = chan_r;
    pol_nxt    = pol_r;
    burst_nxt  = burst_r;
    step_nxt   = step_r;
    mode_nxt   = mode_r;
    ena_nxt    = ena_r;
    ovr_ie_nxt = ovr_ie_r;
    if (wr_acc && (sel == SEL_CTRL))
    begin
      chan_nxt  = pwdata[`SEQB_CHAN_LSB +: `SEQB_CHAN_W];
      pol_nxt   = pwdata[`SEQB_POL_BIT];
      burst_nxt = pwdata[`SEQB_BURST_BIT];
      step_nxt  = pwdata[`SEQB_STEP_BIT];
      mode_nxt  = pwdata[`SEQB_MODE_BIT];
      ena_nxt   = pwdata[`SEQB_ENABLE_BIT];
    end
    if (wr_acc && (sel == SEL_AUX))
      ovr_ie_nxt = pwdata[`SEQB_AUX_OVRIE_BIT];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      chan_r   <= 12'h000;
      pol_r    <= 1'b0;
      burst_r  <= 1'b0;
      step_r   <= 1'b0;
      mode_r   <= 1'b0;
      ena_r    <= 1'b0;
      ovr_ie_r <= 1'b0;
    end
    else
    begin
      chan_r   <= chan_nxt;
      pol_r    <= pol_nxt;
      burst_r  <= burst_nxt;
      step_r   <= step_nxt;
      mode_r   <= mode_nxt;
      ena_r    <= ena_nxt;
      ovr_ie_r <= ovr_ie_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // trigger edge detection

  logic trig_lvl;
  logic act;
  logic act_prev_r, act_prev_nxt;
  logic hw_edge;
  logic trig;

  trig_sync u_sync
  (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (trig_pin),
    .sync_out (trig_lvl)
  );

  always_comb
  begin
    act          = pol_r ? trig_lvl : !trig_lvl;
    act_prev_nxt = ena_r ? act : 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      act_prev_r <= 1'b0;
    else
      act_prev_r <= act_prev_nxt;
  end

  assign hw_edge = act && !act_prev_r;
  assign trig    = ena_r && !burst_r && (hw_edge || start_pulse);

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  seq_state_t  state_r, state_nxt;
  logic [3:0]  cur_r, cur_nxt;
  logic [4:0]  ptr_r, ptr_nxt;
  logic        cont_r, cont_nxt;
  logic        start_r, start_nxt;
  logic        eos;
  logic [4:0]  first;
  logic [4:0]  after;

  assign first = find_chan(chan_r, ptr_r);
  assign after = find_chan(chan_r, {1'b0, cur_r} + 5'h01);

  always_comb
  begin
    state_nxt = state_r;
    cur_nxt   = cur_r;
    ptr_nxt   = ptr_r;
    cont_nxt  = cont_r;
    start_nxt = 1'b0;
    eos       = 1'b0;
    case (state_r)
      ST_IDLE:
      begin
        if (!ena_r)
          cont_nxt = 1'b0;
        else if (!first[4])
          ptr_nxt = 5'h00;
        else if (burst_r || cont_r || trig)
        begin
          state_nxt = ST_CONV;
          cur_nxt   = first[3:0];
          start_nxt = 1'b1;
        end
      end
      ST_CONV:
      begin
        if (conv_done)
        begin
          state_nxt = ST_IDLE;
          eos       = !after[4];
          ptr_nxt   = eos ? 5'h00 : {1'b0, cur_r} + 5'h01;
          cont_nxt  = !eos && !step_r && ena_r;
        end
      end
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= ST_IDLE;
      cur_r   <= 4'h0;
      ptr_r   <= 5'h00;
      cont_r  <= 1'b0;
      start_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cur_r   <= cur_nxt;
      ptr_r   <= ptr_nxt;
      cont_r  <= cont_nxt;
      start_r <= start_nxt;
    end
  end

  assign conv_start = start_r;
  assign conv_chan  = cur_r;

  ////////////////////////////////////////////////////////////////////////////
  // result, overrun and sequence flag

  logic [11:0] res_r, res_nxt;
  logic        valid_r, valid_nxt;
  logic        ovr_r, ovr_nxt;
  logic        eos_flag_r, eos_flag_nxt;
  logic        aux_clr;

  assign aux_clr = wr_acc && (sel == SEL_AUX) && pwdata[`SEQB_AUX_FLAG_BIT];

  always_comb
  begin
    res_nxt      = res_r;
    valid_nxt    = valid_r;
    ovr_nxt      = ovr_r;
    eos_flag_nxt = eos_flag_r;
    if (conv_done && (state_r == ST_CONV))
    begin
      res_nxt   = conv_result;
      valid_nxt = 1'b1;
      ovr_nxt   = !rd_clear && (ovr_r || valid_r);
    end
    else if (rd_clear)
    begin
      valid_nxt = 1'b0;
      ovr_nxt   = 1'b0;
    end
    if (aux_clr || dma_clear)
      eos_flag_nxt = 1'b0;
    if (eos && mode_r)
      eos_flag_nxt = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      res_r      <= 12'h000;
      valid_r    <= 1'b0;
      ovr_r      <= 1'b0;
      eos_flag_r <= 1'b0;
    end
    else
    begin
      res_r      <= res_nxt;
      valid_r    <= valid_nxt;
      ovr_r      <= ovr_nxt;
      eos_flag_r <= eos_flag_nxt;
    end
  end

  assign seq_flag     = mode_r ? eos_flag_r : valid_r;
  assign overrun_flag = !mode_r && ovr_ie_r && ovr_r;

  ////////////////////////////////////////////////////////////////////////////
  // read data

  logic [31:0] rdata_r, rdata_nxt;
  logic [3:0]  chn_r, chn_nxt;

  assign chn_nxt = (conv_done && (state_r == ST_CONV)) ? cur_r : chn_r;

  always_comb
  begin
    rdata_nxt = rdata_r;
    if (setup)
    begin
      rdata_nxt = 32'h0000_0000;
      if (sel == SEL_CTRL)
      begin
        rdata_nxt[`SEQB_CHAN_LSB +: `SEQB_CHAN_W] = chan_r;
        rdata_nxt[`SEQB_POL_BIT]   = pol_r;
        rdata_nxt[`SEQB_BURST_BIT] = burst_r;       // start bit stays zero
        rdata_nxt[`SEQB_STEP_BIT]  = step_r;
        rdata_nxt[`SEQB_MODE_BIT]  = mode_r;
        rdata_nxt[`SEQB_ENABLE_BIT] = ena_r;
      end
      else if (sel == SEL_RESULT)
      begin
        rdata_nxt[`SEQB_RES_LSB +: 12] = res_r;
        rdata_nxt[`SEQB_CHN_LSB +: 4]  = chn_r;
        rdata_nxt[`SEQB_OVR_BIT]       = ovr_r;
        rdata_nxt[`SEQB_VALID_BIT]     = valid_r;
      end
      else if (sel == SEL_AUX)
      begin
        rdata_nxt[`SEQB_AUX_FLAG_BIT]  = eos_flag_r;
        rdata_nxt[`SEQB_AUX_OVRIE_BIT] = ovr_ie_r;
        rdata_nxt[`SEQB_AUX_BUSY_BIT]  = (state_r == ST_CONV) || cont_r;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rdata_r <= 32'h0000_0000;
      chn_r   <= 4'h0;
    end
    else
    begin
      rdata_r <= rdata_nxt;
      chn_r   <= chn_nxt;
    end
  end

  assign prdata = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence idle_ready_s;
    (state_r == ST_IDLE) && ena_r && first[4];
  endsequence

  sequence pass_end_s;
    (state_r == ST_CONV) && conv_done && !after[4];
  endsequence

  start_reads_zero_a: assert property (
    rd_acc && (sel == SEL_CTRL) |-> !prdata[`SEQB_START_BIT])
    else $error("start bit read back as one");

  sw_start_launch_a: assert property (
    idle_ready_s and start_pulse ##0 !burst_r |=> conv_start && state_r == ST_CONV)
    else $error("software start did not launch");

  burst_repeat_a: assert property (
    idle_ready_s and burst_r |=> conv_start)
    else $error("burst did not relaunch");

  disabled_quiet_a: assert property (
    !ena_r && (state_r == ST_IDLE) |=> !conv_start)
    else $error("conversion started while disabled");

  step_halt_a: assert property (
    step_r && !burst_r && (state_r == ST_CONV) && conv_done
      |=> (!trig && !burst_r |=> !conv_start))
    else $error("single step ran past one channel");

  mirror_valid_a: assert property (
    !mode_r && (state_r == ST_CONV) && conv_done |=> seq_flag)
    else $error("flag does not mirror result valid");

  overrun_gate_a: assert property (
    mode_r |-> !overrun_flag)
    else $error("overrun contributed in sequence mode");

  eos_flag_set_a: assert property (
    pass_end_s and mode_r |=> seq_flag)
    else $error("end of pass flag not set");

  enable_launch_a: assert property (
    $rose(ena_r) && act && first[4] && !burst_r && state_r == ST_IDLE
      |-> ##[1:2] conv_start)
    else $error("enable with active trigger did not launch");

  disable_stop_a: assert property (
    !ena_r && (state_r == ST_CONV) && conv_done |=> ##1 !conv_start [*2])
    else $error("conversions continued after disable");

endmodule : seqb_launch

/* File: tb/conv_core_model.sv */
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// converter core stand-in: answers each launch after 2 or 10 cycles
module conv_core_model
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // launch side
  input  wire logic        conv_start,
  input  wire logic [3:0]  conv_chan,
  input  wire logic        slow,
  // answer side
  output logic             conv_done,
  output logic      [11:0] conv_result
);
  logic       busy_r;
  logic [3:0] cnt_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      busy_r      <= 1'b0;
      cnt_r       <= 4'h0;
      conv_done   <= 1'b0;
      conv_result <= 12'h000;
    end
    else
    begin
      conv_done   <= 1'b0;
      // stale outside done, keep it moving
      conv_result <= ~conv_result;
      if (conv_start)
      begin
        busy_r <= 1'b1;
        cnt_r  <= slow ? 4'h9 : 4'h1;
      end
      else if (busy_r && cnt_r == 4'h0)
      begin
        busy_r      <= 1'b0;
        conv_done   <= 1'b1;
        conv_result <= {conv_chan, 8'ha5};
      end
      else if (busy_r)
        cnt_r <= cnt_r - 4'h1;
    end
  end
endmodule : conv_core_model

/* File: tb/tb_top.sv */
`timescale 1ns/100ps
`include "seqb_defs.svh"
module tb_top
  import seqb_pkg::*;
;
  localparam logic [11:0] CTRL = `SEQB_CONTROL_OFS;
  localparam logic [11:0] RES  = `SEQB_RESULT_OFS;
  localparam logic [11:0] AUX  = `SEQB_AUX_OFS;
  localparam logic [31:0] EN   = 32'h1 << `SEQB_ENABLE_BIT;
  localparam logic [31:0] MD   = 32'h1 << `SEQB_MODE_BIT;
  localparam logic [31:0] ST   = 32'h1 << `SEQB_STEP_BIT;
  localparam logic [31:0] BU   = 32'h1 << `SEQB_BURST_BIT;
  // start never with burst, reserved bit never set
  localparam logic [31:0] GO   = 32'h1 << `SEQB_START_BIT;
  localparam logic [31:0] PO   = 32'h1 << `SEQB_POL_BIT;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        trig_pin, dma_clear, slow, conv_start, conv_done, seq_flag, overrun_flag;
  logic [11:0] paddr, conv_result;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  conv_chan;
  logic [3:0]  chans_q[$];
  int          mismatches, tests_run;

  ////////////////////////////////////////////////////////////////////////////////
  seqb_launch u_seqb_launch (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .trig_pin(trig_pin), .conv_start(conv_start), .conv_chan(conv_chan),
    .conv_done(conv_done), .conv_result(conv_result), .dma_clear(dma_clear),
    .seq_flag(seq_flag), .overrun_flag(overrun_flag));
  conv_core_model u_conv_core_model (.pclk(pclk), .presetn(presetn), .conv_start(conv_start),
    .conv_chan(conv_chan), .slow(slow), .conv_done(conv_done), .conv_result(conv_result));

  always #2 pclk = ~pclk;

  // log every launched channel
  always @(posedge pclk)
    if (conv_start === 1'b1)
      chans_q.push_back(conv_chan);

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask : idle

  // count in top nibble, first channel in lowest nibble
  function automatic logic [31:0] qv();
    logic [31:0] v;
    v = 32'(chans_q.size()) << 28;
    foreach (chans_q[i])
      v[4*i +: 4] = chans_q[i];
    return v;
  endfunction : qv

  task automatic end_of_test();
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test

  initial
  begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    end_of_test();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0; trig_pin = 1'b1; dma_clear = 1'b0; slow = 1'b0;
    mismatches = 0; tests_run = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, CTRL, 32'h0);
    chk("ctrl reset", rd, `SEQB_CONTROL_RST);
    apb(1'b0, 12'h100, 32'h0);
    chk("unmapped error", 32'(err), 32'h1);
    chk("unmapped reads zero", rd, 32'h0);
    apb(1'b1, AUX, 32'h2);
    // full pass from software start
    apb(1'b1, CTRL, EN | 32'h052);
    apb(1'b1, CTRL, EN | GO | 32'h052);
    idle(60);
    chk("pass channels", qv(), 32'h3000_0641);
    apb(1'b0, CTRL, 32'h0);
    chk("start reads zero", rd, EN | 32'h052);
    chk("flag mode zero", 32'(seq_flag), 32'h1);
    chk("overrun mode zero", 32'(overrun_flag), 32'h1);
    apb(1'b0, RES, 32'h0);
    chk("result word", {14'h0, rd[31:26], rd[15:4]}, 32'h0003_66a5);
    idle(2);
    chk("flags cleared", 32'({seq_flag, overrun_flag}), 32'h0);
    // single step, end of sequence mode
    slow <= 1'b1;
    chans_q.delete();
    apb(1'b1, CTRL, EN | MD | ST | 32'h003);
    apb(1'b1, AUX, 32'h3);
    apb(1'b1, CTRL, EN | MD | ST | GO | 32'h003);
    idle(40);
    chk("step one", qv(), 32'h1000_0000);
    chk("no flag mid pass", 32'(seq_flag), 32'h0);
    apb(1'b1, CTRL, EN | MD | ST | GO | 32'h003);
    idle(40);
    chk("step two", qv(), 32'h2000_0010);
    chk("flag at pass end", 32'(seq_flag), 32'h1);
    chk("overrun mode one", 32'(overrun_flag), 32'h0);
    apb(1'b0, AUX, 32'h0);
    chk("aux flag and enable", rd, 32'h3);
    dma_clear <= 1'b1;
    @(posedge pclk);
    dma_clear <= 1'b0;
    idle(2);
    chk("dma clear", 32'(seq_flag), 32'h0);
    apb(1'b1, CTRL, EN | MD | ST | GO | 32'h003);
    idle(40);
    chk("step wraps", qv(), 32'h3000_0010);
    // burst cycling
    slow <= 1'b0;
    chans_q.delete();
    apb(1'b1, CTRL, EN | BU | 32'h300);
    idle(30);
    chk("burst repeats", 32'(chans_q.size() > 3), 32'h1);
    apb(1'b1, CTRL, EN | 32'h300);
    idle(30);
    chk("burst stop at end", 32'({1'(chans_q.size() % 2), chans_q[$]}), 32'h9);
    // hardware trigger edges and enable
    chans_q.delete();
    apb(1'b1, CTRL, 32'h010);
    trig_pin <= 1'b0;
    idle(8);
    trig_pin <= 1'b1;
    idle(8);
    chk("disabled ignores", qv(), 32'h0);
    apb(1'b1, CTRL, EN | 32'h010);
    trig_pin <= 1'b0;
    idle(10);
    chk("falling launches", qv(), 32'h1000_0004);
    trig_pin <= 1'b1;
    idle(10);
    chk("rising ignored", qv(), 32'h1000_0004);
    apb(1'b1, CTRL, PO | 32'h010);
    apb(1'b1, CTRL, EN | PO | 32'h010);
    idle(10);
    chk("enable while active", qv(), 32'h2000_0044);
    trig_pin <= 1'b0;
    idle(8);
    trig_pin <= 1'b1;
    idle(10);
    chk("rising launches", qv(), 32'h3000_0444);
    // disable in mid pass, then resume
    slow <= 1'b1;
    chans_q.delete();
    apb(1'b1, CTRL, 32'h007);
    apb(1'b1, CTRL, EN | 32'h007);
    apb(1'b1, CTRL, EN | GO | 32'h007);
    while (chans_q.size() == 0)
      @(posedge pclk);
    apb(1'b1, CTRL, 32'h007);
    idle(40);
    chk("halt after current", qv(), 32'h1000_0000);
    apb(1'b1, CTRL, EN | 32'h007);
    idle(20);
    chk("waits for trigger", qv(), 32'h1000_0000);
    apb(1'b1, CTRL, EN | GO | 32'h007);
    idle(60);
    chk("resumes next", qv(), 32'h3000_0210);
    end_of_test();
  end
endmodule : tb_top
